//--- common/rtca_params.svh
// Constants of the calendar and alarm block: offsets, field positions,
// write masks, reset values and timing counts.
// Assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus.
`ifndef RTCA_PARAMS_SVH
`define RTCA_PARAMS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define RTCA_OFS_CTRL      6'h00
`define RTCA_OFS_DATE      6'h04
`define RTCA_OFS_ATIME     6'h08
`define RTCA_OFS_ADATE     6'h0c
`define RTCA_OFS_ALARM     6'h10
`define RTCA_OFS_TIME      6'h14
`define RTCA_OFS_STATUS    6'h18
`define RTCA_OFS_IRQ_EN    6'h1c
`define RTCA_OFS_IRQ_CLR   6'h20

// ****************************************************************
// Field positions
// ****************************************************************
`define RTCA_WREN_BIT      3
`define RTCA_YEAR_T_MSB    31
`define RTCA_YEAR_T_LSB    28
`define RTCA_YEAR_U_MSB    27
`define RTCA_YEAR_U_LSB    24
`define RTCA_MON_MSB       20
`define RTCA_MON_LSB       16
`define RTCA_HOUR_MSB      29
`define RTCA_HOUR_LSB      24
`define RTCA_MIN_MSB       22
`define RTCA_MIN_LSB       16
`define RTCA_MDAY_MSB      13
`define RTCA_MDAY_LSB      8
`define RTCA_SEC_MSB       14
`define RTCA_SEC_LSB       8
`define RTCA_SEC_U_MSB     11
`define RTCA_SEC_U_LSB     8
`define RTCA_WDAY_MSB      2
`define RTCA_WDAY_LSB      0
`define RTCA_AEN_BIT       15
`define RTCA_CHIME_BIT     14
`define RTCA_AMSK_MSB      11
`define RTCA_AMSK_LSB      8
`define RTCA_ST_ALARM      0
`define RTCA_ST_REFUSED    1

// ****************************************************************
// Implemented-bit masks and reset values
// ****************************************************************
`define RTCA_DATE_MASK     32'hff1f3f07
`define RTCA_ATIME_MASK    32'h3f7f7f00
`define RTCA_ADATE_MASK    32'h001f3f07
`define RTCA_TIME_MASK     32'h3f7f7f00
`define RTCA_RST_WORD      32'h00000000
`define RTCA_LAST_SEC      8'h59
`define RTCA_LAST_MIN      8'h59
`define RTCA_LAST_HOUR     8'h23
`define RTCA_LAST_WDAY     3'h6
`define RTCA_RPT_TOP       8'hff

// ****************************************************************
// Timing
// ****************************************************************
`define RTCA_CLK_HZ        100000000
`define RTCA_HALF_SEC_MS   500
`define RTCA_HALF_SEC_CYC  (`RTCA_CLK_HZ / 1000 * `RTCA_HALF_SEC_MS)

`endif

//--- common/rtca_pkg.sv
// Types of the calendar and alarm block.
// Assumes rtca_params.svh is on the include path.
package rtca_pkg;

    // ************************************************************
    // Alarm match selections
    // ************************************************************
    typedef enum logic [3:0] {
        AMS_HALF_SEC = 4'h0,
        AMS_SECOND   = 4'h1,
        AMS_TEN_SEC  = 4'h2,
        AMS_MINUTE   = 4'h3,
        AMS_TEN_MIN  = 4'h4,
        AMS_HOUR     = 4'h5,
        AMS_DAY      = 4'h6,
        AMS_WEEK     = 4'h7,
        AMS_MONTH    = 4'h8,
        AMS_YEAR     = 4'h9
    } rtca_amsk_t;

    // ************************************************************
    // Whole state of the top module
    // ************************************************************
    typedef struct packed {
        logic        wreq;
        logic [31:0] rdata;
        logic        irq;
        logic        wren;
        logic [31:0] date;
        logic [31:0] atime;
        logic [31:0] adate;
        logic [31:0] time_v;
        logic        half;
        logic [25:0] cnt;
        logic        pend;
        logic        aen;
        logic        chime;
        logic [3:0]  amsk;
        logic [7:0]  rpt;
        logic [1:0]  status;
        logic [1:0]  irq_en;
    } rtca_state_t;

endpackage

//--- dv/rtca_checker.sv
// Checker of the calendar and alarm block, bound to rtca_top.
// Assumes it sees only the top module's ports, in one clock domain.
`timescale 1ns/1ps

module rtca_checker
#(
    parameter int HALF_SEC_CYCLES = 8
)
(
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    // Avalon-MM slave
    input wire logic [5:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // Interrupt
    input wire logic        irq
);
    logic        wren_ff;
    logic [31:0] date_ff;
    logic        wr_done;
    logic        rd_done;

    assign wr_done = avs_write && !avs_waitrequest;
    assign rd_done = avs_read && !avs_waitrequest;

    // Shadow of the date word; a write while the enable is low is lost.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            wren_ff <= 1'b0;
            date_ff <= 32'h0;
        end
        else if (wr_done)
        begin
            if (avs_address == 6'h00 && avs_byteenable[0])
                wren_ff <= avs_writedata[3];
            for (int i = 0; i < 4; i++)
                if (avs_address == 6'h04 && wren_ff && avs_byteenable[i])
                    date_ff[8*i +: 8] <= avs_writedata[8*i +: 8];
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("wait state not one cycle");
    wait_pulse_a: assert property ($fell(avs_waitrequest)
        |-> ##1 $rose(avs_waitrequest)) else $error("waitrequest stuck low");
    idle_wait_a: assert property (!(avs_read || avs_write) && avs_waitrequest
        |=> avs_waitrequest) else $error("answer without request");
    rst_state_a: assert property ($fell(sys_rst) |-> avs_waitrequest && !irq
        && avs_readdata == 32'h0) else $error("outputs not cleared");
    date_zero_a: assert property (
        rd_done && avs_address == 6'h04 |-> (avs_readdata & ~32'hff1f3f07)
        == 32'h0) else $error("date unused bits set");
    atime_zero_a: assert property (
        rd_done && avs_address == 6'h08 |-> (avs_readdata & ~32'h3f7f7f00)
        == 32'h0) else $error("alarm time unused bits set");
    adate_zero_a: assert property (
        rd_done && avs_address == 6'h0c |-> (avs_readdata & ~32'h001f3f07)
        == 32'h0) else $error("alarm date unused bits set");
    date_guard_a: assert property (
        rd_done && avs_address == 6'h04 |-> avs_readdata
        == (date_ff & 32'hff1f3f07)) else $error("date word wrong");

    cover property (wr_done && avs_address == 6'h04 && !wren_ff);
    cover property ($rose(irq));
    cover property (rd_done && avs_address == 6'h10);
endmodule

//--- dv/tb_rtca_top.sv
// Self-checking bench of the calendar and alarm block.
// Assumes rtca_top and rtca_checker are compiled; no other model.
`timescale 1ns/1ps

module tb_rtca_top;
    localparam int HALF = 8;
    logic        clk_sys        = 1'b0;
    logic        sys_rst        = 1'b1;
    logic [5:0]  avs_address    = 6'h00;
    logic        avs_read       = 1'b0;
    logic        avs_write      = 1'b0;
    logic [31:0] avs_writedata  = 32'h0;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        irq;
    int          miscompares    = 0;
    int          checked        = 0;
    integer      seed           = 32'he115a5e7;
    logic [31:0] exp_q[$];
    logic [31:0] shadow [0:3]   = '{default: 32'h0};
    logic [31:0] wmask [0:3]    = '{32'h8, 32'hff1f3f07, 32'h3f7f7f00,
                                    32'h001f3f07};

    always #5 clk_sys = ~clk_sys;

    rtca_top #(.HALF_SEC_CYCLES(HALF)) DUT (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .irq(irq));

    task automatic check(input string what, input logic [31:0] e,
                         input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %s exp %h got %h", what, e, g);
        end
    endtask

    task automatic report_and_stop();
        if (miscompares == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // One bus access, held until waitrequest is seen low; only the
    // watchdog ends a wait that never gets its answer.
    task automatic bus(input logic r, input logic [5:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= r;
        avs_write <= !r;
        do
        begin
            @(posedge clk_sys);
        end
        while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d,
                      input logic [3:0] be);
        bus(1'b0, a, d, be);
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b1, a, 32'h0, 4'h0);
    endtask

    task automatic wait_irq(input int lim);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < lim)
        begin
            @(posedge clk_sys);
            n++;
        end
        check("irq raised", 32'h1, {31'h0, irq});
    endtask

    task automatic irq_is(input logic v);
        repeat (2) @(posedge clk_sys);
        check("irq level", {31'h0, v}, {31'h0, irq});
    endtask

    // Takes the oldest note whenever a read completes.
    always @(posedge clk_sys)
    begin
        if (avs_read && avs_waitrequest === 1'b0)
            check($sformatf("read 0x%h", avs_address), exp_q.pop_front(),
                  avs_readdata);
    end

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        report_and_stop();
    end

    initial
    begin
        int          idx;
        logic [31:0] d;
        logic [3:0]  be;
        logic        wren;
        wren = 1'b0;
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        // The running time at 0x14 moves on its own, so it is skipped.
        for (int a = 0; a <= 9; a++)
            if (a != 5)
                rd(6'(a * 4), 32'h0);
        wr(6'h04, 32'hffffffff, 4'hf);
        rd(6'h04, 32'h0);
        for (int i = 0; i < 40; i++)
        begin
            idx = $random(seed) & 3;
            d = $random(seed);
            be = 4'($random(seed));
            wr(6'(idx * 4), d, be);
            for (int b = 0; b < 4; b++)
                if (be[b] && (idx != 1 || wren))
                    shadow[idx][8*b +: 8] = d[8*b +: 8];
            if (idx == 0 && be[0])
                wren = d[3];
            d = shadow[idx] & wmask[idx];
            case (idx)
                0: rd(6'h00, d);
                1: rd(6'h04, d);
                2: rd(6'h08, d);
                3: rd(6'h0c, d);
                default: ;
            endcase
        end
        rd(6'h18, 32'h2);
        wr(6'h00, 32'h8, 4'hf);
        wr(6'h20, 32'h3, 4'hf);
        wr(6'h1c, 32'h1, 4'hf);
        // Seconds-only match: the event must come when seconds reach 02.
        wr(6'h14, 32'h0, 4'hf);
        wr(6'h08, 32'h00000200, 4'hf);
        wr(6'h10, 32'h00008300, 4'hf);
        wait_irq(80);
        rd(6'h14, 32'h00000200);
        rd(6'h10, 32'h00000300);
        wr(6'h1c, 32'h0, 4'hf);
        irq_is(1'b0);
        wr(6'h1c, 32'h1, 4'hf);
        irq_is(1'b1);
        wr(6'h20, 32'h1, 4'hf);
        irq_is(1'b0);
        // With chime an empty repeat count wraps to its top value.
        wr(6'h10, 32'h0000c000, 4'h3);
        wait_irq(30);
        wr(6'h10, 32'h0, 4'h2);
        rd(6'h10, 32'h000000ff);
        rd(6'h18, 32'h1);
        @(posedge clk_sys);
        report_and_stop();
    end
endmodule

bind rtca_top rtca_checker #(.HALF_SEC_CYCLES(HALF_SEC_CYCLES)) u_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq));

//--- rtl/rtca_match.sv
// Alarm comparator: tells whether the running time and date equal the
// alarm fields chosen by the match selection.
// Assumes all inputs are registered values of one clock domain.
`timescale 1ns/1ps
`include "rtca_params.svh"

module rtca_match
    import rtca_pkg::*;
(
    // Selection and half-second phase
    input  wire logic [3:0]  amsk,
    input  wire logic        half,
    // Running values
    input  wire logic [31:0] time_v,
    input  wire logic [31:0] date,
    // Alarm values
    input  wire logic [31:0] atime,
    input  wire logic [31:0] adate,
    // Result
    output logic             hit
);

    logic su;
    logic sc;
    logic mu;
    logic mn;
    logic hr;
    logic wd;
    logic md;
    logic mo;

    assign su = time_v[`RTCA_SEC_U_MSB:`RTCA_SEC_U_LSB]
             == atime[`RTCA_SEC_U_MSB:`RTCA_SEC_U_LSB];
    assign sc = time_v[`RTCA_SEC_MSB:`RTCA_SEC_LSB]
             == atime[`RTCA_SEC_MSB:`RTCA_SEC_LSB];
    assign mu = time_v[19:16] == atime[19:16];
    assign mn = time_v[`RTCA_MIN_MSB:`RTCA_MIN_LSB]
             == atime[`RTCA_MIN_MSB:`RTCA_MIN_LSB];
    assign hr = time_v[`RTCA_HOUR_MSB:`RTCA_HOUR_LSB]
             == atime[`RTCA_HOUR_MSB:`RTCA_HOUR_LSB];
    assign wd = date[`RTCA_WDAY_MSB:`RTCA_WDAY_LSB]
             == adate[`RTCA_WDAY_MSB:`RTCA_WDAY_LSB];
    assign md = date[`RTCA_MDAY_MSB:`RTCA_MDAY_LSB]
             == adate[`RTCA_MDAY_MSB:`RTCA_MDAY_LSB];
    assign mo = date[`RTCA_MON_MSB:`RTCA_MON_LSB]
             == adate[`RTCA_MON_MSB:`RTCA_MON_LSB];

    // Whole-second selections fire on the second boundary only.
    always_comb
    begin
        hit = 1'b0;
        case (rtca_amsk_t'(amsk))
            AMS_HALF_SEC: hit = 1'b1;
            AMS_SECOND:   hit = !half;
            AMS_TEN_SEC:  hit = !half && su;
            AMS_MINUTE:   hit = !half && sc;
            AMS_TEN_MIN:  hit = !half && sc && mu;
            AMS_HOUR:     hit = !half && sc && mn;
            AMS_DAY:      hit = !half && sc && mn && hr;
            AMS_WEEK:     hit = !half && sc && mn && hr && wd;
            AMS_MONTH:    hit = !half && sc && mn && hr && md;
            AMS_YEAR:     hit = !half && sc && mn && hr && md && mo;
            default:      hit = 1'b0;
        endcase
    end

endmodule

//--- rtl/rtca_top.sv
// Calendar date register, alarm time and date registers, a running
// time counter and the alarm event logic, behind an Avalon-MM slave.
// Assumes one 100 MHz clock, synchronous inputs and a master that
// holds each request until waitrequest is seen low.
//
// Operation
// - The date word keeps the year tens digit in 31:28 and units in 27:24.
// - The date word keeps the month tens bit at 20 and units in 19:16.
// - The date word keeps the day tens digit in 13:12 and units in 11:8.
// - The date word keeps a weekday code of 0 to 6 in bits 2:0.
// - Date writes take effect only while the clock write enable bit is one.
// - Date bits 23:21, 15:14 and 7:3 are not stored and read as zero.
// - The alarm time word keeps hour tens in 29:28 and units in 27:24.
// - The alarm time word keeps minute tens in 22:20 and units in 19:16.
// - The alarm time word keeps second tens in 14:12 and units in 11:8.
// - Alarm time bits 31:30, 23, 15 and 7:0 read as zero.
// - The alarm date word keeps month tens at 20 and units in 19:16.
// - The alarm date word keeps day tens in 13:12 and units in 11:8.
// - The alarm date word keeps a weekday code of 0 to 6 in bits 2:0.
// - Alarm date bits 31:21, 15:14 and 7:3 read as zero.
// - Each alarm event lowers a nonzero repeat count; at zero it wraps with chime, else clears the alarm enable.
`timescale 1ns/1ps
`include "rtca_params.svh"

module rtca_top
    import rtca_pkg::*;
#(
    parameter int HALF_SEC_CYCLES = `RTCA_HALF_SEC_CYC
)
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // Avalon-MM slave
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Interrupt
    output logic             irq
);

    // ************************************************************
    // Helpers
    // ************************************************************
    localparam logic [25:0] CNT_LAST = 26'(HALF_SEC_CYCLES - 1);

    // Byte-lane merge followed by the implemented-bit mask.
    function automatic logic [31:0] merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  be,
        input logic [31:0] keep
    );
        logic [31:0] lanes;
        lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return ((new_v & lanes) | (old_v & ~lanes)) & keep;
    endfunction

    // Two-digit BCD step; returns the carry above the new value.
    function automatic logic [8:0] bcd_step(
        input logic [7:0] v,
        input logic [7:0] last
    );
        logic [8:0] r;
        r = 9'h000;
        if (v == last)
        begin
            r = 9'h100;
        end
        else if (v[3:0] == 4'h9)
        begin
            r = {1'b0, v[7:4] + 4'h1, 4'h0};
        end
        else
        begin
            r = {1'b0, v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    rtca_state_t s_ff;
    rtca_state_t nxt_s;
    logic        hit;
    logic        acc;
    logic        done;
    logic        tick;
    logic        evt;
    logic        refused;
    logic [1:0]  clr;
    logic [8:0]  sec_n;
    logic [8:0]  min_n;
    logic [8:0]  hour_n;
    logic [31:0] rd_v;

    rtca_match u_match (
        .amsk   (s_ff.amsk),
        .half   (s_ff.half),
        .time_v (s_ff.time_v),
        .date   (s_ff.date),
        .atime  (s_ff.atime),
        .adate  (s_ff.adate),
        .hit    (hit)
    );

    // ************************************************************
    // Read multiplexer
    // ************************************************************
    // Stored words are already masked, so unused bits read as zero.
    always_comb
    begin
        rd_v = `RTCA_RST_WORD;
        if (avs_address == `RTCA_OFS_CTRL)
        begin
            rd_v[`RTCA_WREN_BIT] = s_ff.wren;
        end
        else if (avs_address == `RTCA_OFS_DATE)
        begin
            rd_v = s_ff.date;
        end
        else if (avs_address == `RTCA_OFS_ATIME)
        begin
            rd_v = s_ff.atime;
        end
        else if (avs_address == `RTCA_OFS_ADATE)
        begin
            rd_v = s_ff.adate;
        end
        else if (avs_address == `RTCA_OFS_ALARM)
        begin
            rd_v[`RTCA_AEN_BIT] = s_ff.aen;
            rd_v[`RTCA_CHIME_BIT] = s_ff.chime;
            rd_v[`RTCA_AMSK_MSB:`RTCA_AMSK_LSB] = s_ff.amsk;
            rd_v[7:0] = s_ff.rpt;
        end
        else if (avs_address == `RTCA_OFS_TIME)
        begin
            rd_v = s_ff.time_v;
        end
        else if (avs_address == `RTCA_OFS_STATUS)
        begin
            rd_v[1:0] = s_ff.status;
        end
        else if (avs_address == `RTCA_OFS_IRQ_EN)
        begin
            rd_v[1:0] = s_ff.irq_en;
        end
        else
        begin
            rd_v = `RTCA_RST_WORD;
        end
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        nxt_s = s_ff;
        acc = (avs_read || avs_write) && s_ff.wreq;
        done = (avs_read || avs_write) && !s_ff.wreq;
        tick = s_ff.cnt == CNT_LAST;
        evt = s_ff.pend && s_ff.aen && hit;
        refused = 1'b0;
        clr = 2'b00;
        sec_n = bcd_step(s_ff.time_v[15:8], `RTCA_LAST_SEC);
        min_n = bcd_step(s_ff.time_v[23:16], `RTCA_LAST_MIN);
        hour_n = bcd_step(s_ff.time_v[31:24], `RTCA_LAST_HOUR);

        // One wait state: a request seen with waitrequest high is
        // answered on the next edge, so back-to-back accesses work.
        nxt_s.wreq = !acc;
        if (acc && avs_read)
        begin
            nxt_s.rdata = rd_v;
        end

        // Half-second divider and running time.
        nxt_s.pend = tick;
        nxt_s.cnt = tick ? 26'h0000000 : s_ff.cnt + 26'h0000001;
        if (tick)
        begin
            nxt_s.half = !s_ff.half;
            if (s_ff.half)
            begin
                nxt_s.time_v[15:8] = sec_n[7:0];
                if (sec_n[8])
                begin
                    nxt_s.time_v[23:16] = min_n[7:0];
                    if (min_n[8])
                    begin
                        nxt_s.time_v[31:24] = hour_n[7:0];
                    end
                end
                // Only the weekday follows midnight; the day of month
                // is left to software, which knows the month lengths.
                if (sec_n[8] && min_n[8] && hour_n[8])
                begin
                    if (s_ff.date[`RTCA_WDAY_MSB:`RTCA_WDAY_LSB]
                        == `RTCA_LAST_WDAY)
                    begin
                        nxt_s.date[`RTCA_WDAY_MSB:`RTCA_WDAY_LSB] = 3'h0;
                    end
                    else
                    begin
                        nxt_s.date[`RTCA_WDAY_MSB:`RTCA_WDAY_LSB] =
                            s_ff.date[`RTCA_WDAY_MSB:`RTCA_WDAY_LSB]
                            + 3'h1;
                    end
                end
            end
        end

        // Alarm repeat count.
        if (evt)
        begin
            if (s_ff.rpt != 8'h00)
            begin
                nxt_s.rpt = s_ff.rpt - 8'h01;
            end
            else if (s_ff.chime)
            begin
                nxt_s.rpt = `RTCA_RPT_TOP;
            end
            else
            begin
                nxt_s.aen = 1'b0;
            end
        end

        // Register writes land on the edge that completes the access.
        if (done && avs_write)
        begin
            if (avs_address == `RTCA_OFS_CTRL)
            begin
                if (avs_byteenable[0])
                begin
                    nxt_s.wren = avs_writedata[`RTCA_WREN_BIT];
                end
            end
            else if (avs_address == `RTCA_OFS_DATE)
            begin
                if (s_ff.wren)
                begin
                    nxt_s.date = merge(s_ff.date, avs_writedata,
                        avs_byteenable, `RTCA_DATE_MASK);
                end
                else
                begin
                    refused = 1'b1;
                end
            end
            else if (avs_address == `RTCA_OFS_ATIME)
            begin
                nxt_s.atime = merge(s_ff.atime, avs_writedata,
                    avs_byteenable, `RTCA_ATIME_MASK);
            end
            else if (avs_address == `RTCA_OFS_ADATE)
            begin
                nxt_s.adate = merge(s_ff.adate, avs_writedata,
                    avs_byteenable, `RTCA_ADATE_MASK);
            end
            else if (avs_address == `RTCA_OFS_ALARM)
            begin
                if (avs_byteenable[1])
                begin
                    nxt_s.aen = avs_writedata[`RTCA_AEN_BIT];
                    nxt_s.chime = avs_writedata[`RTCA_CHIME_BIT];
                    nxt_s.amsk =
                        avs_writedata[`RTCA_AMSK_MSB:`RTCA_AMSK_LSB];
                end
                if (avs_byteenable[0])
                begin
                    nxt_s.rpt = avs_writedata[7:0];
                end
            end
            else if (avs_address == `RTCA_OFS_TIME)
            begin
                if (s_ff.wren)
                begin
                    nxt_s.time_v = merge(s_ff.time_v, avs_writedata,
                        avs_byteenable, `RTCA_TIME_MASK);
                    nxt_s.half = 1'b0;
                    nxt_s.cnt = 26'h0000000;
                end
                else
                begin
                    refused = 1'b1;
                end
            end
            else if (avs_address == `RTCA_OFS_IRQ_EN)
            begin
                if (avs_byteenable[0])
                begin
                    nxt_s.irq_en = avs_writedata[1:0];
                end
            end
            else if (avs_address == `RTCA_OFS_IRQ_CLR)
            begin
                if (avs_byteenable[0])
                begin
                    clr = avs_writedata[1:0];
                end
            end
        end

        // Sticky status: a new event wins over a clear in the same cycle.
        nxt_s.status = s_ff.status & ~clr;
        if (evt)
        begin
            nxt_s.status[`RTCA_ST_ALARM] = 1'b1;
        end
        if (refused)
        begin
            nxt_s.status[`RTCA_ST_REFUSED] = 1'b1;
        end
        nxt_s.irq = |(nxt_s.status & nxt_s.irq_en);
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            s_ff <= '0;
            s_ff.wreq <= 1'b1;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    assign avs_readdata = s_ff.rdata;
    assign avs_waitrequest = s_ff.wreq;
    assign irq = s_ff.irq;

endmodule
